// *** hdl/cts_map.vh ***
// Purpose: offsets, fields, reset values and timing figures of the charger supervisor
// Assumes: 40 MHz clock, APB word-aligned register map
// Notes: all durations kept in their own unit; cycle counts derived where used
`ifndef CTS_MAP_VH
`define CTS_MAP_VH

// timing
`define CTS_CLOCK_KHZ 40000
`define CTS_PULSE_US 128
`define CTS_DEGLITCH_US 64
`define CTS_WATCHDOG_MS 12000
`define CTS_MS_PER_MIN 60000
`define CTS_SAFE_MIN_0 16'h001b
`define CTS_SAFE_MIN_1 16'h0168
`define CTS_SAFE_MIN_2 16'h021c
`define CTS_RECOVERY_MIN 27
`define CTS_STARTUP_WAIT 2'h3

// register offsets
`define CTS_OFF_CTRL 12'h000
`define CTS_OFF_TIMER 12'h004
`define CTS_OFF_SETTING 12'h008
`define CTS_OFF_STATUS 12'h00c

// control register fields
`define CTS_CTRL_CHG_DIS 0
`define CTS_CTRL_KICK 1
`define CTS_CTRL_LIM_OFF 2
`define CTS_CTRL_EN_STAT 3
`define CTS_CTRL_LIM_SEL_LO 4
`define CTS_CTRL_LIM_SEL_HI 5
`define CTS_CTRL_ACC_EN 6
`define CTS_CTRL_ACC_LIM_LO 7
`define CTS_CTRL_ACC_LIM_HI 8

// setting register fields
`define CTS_SET_ICHG_LO 0
`define CTS_SET_ICHG_HI 3
`define CTS_SET_VREG_LO 4
`define CTS_SET_VREG_HI 9

// reset values
`define CTS_RST_ICHG 4'h6
`define CTS_RST_VREG 6'h05
`define CTS_RST_LIM_SEL 2'h0
`define CTS_RST_SAFE_SEL 2'h0
`define CTS_RST_ACC_LIM 2'h0

// encodings
`define CTS_STATE_READY 2'h0
`define CTS_STATE_CHARGING 2'h1
`define CTS_STATE_DONE 2'h2
`define CTS_STATE_FAULT 2'h3
`define CTS_FAULT_NONE 3'h0
`define CTS_FAULT_ACCESSORY 3'h1
`define CTS_FAULT_TEMP 3'h3
`define CTS_FAULT_TIMER 3'h4
`define CTS_THERM_NONE 2'h0
`define CTS_THERM_COLD 2'h1
`define CTS_THERM_WARM 2'h2
`define CTS_THERM_HOT 2'h3
`define CTS_SAFE_SEL_OFF 2'h3

`endif

// *** hdl/cts_sync2.v ***
// Purpose: two-flop synchroniser for a group of asynchronous pins
// Assumes: each bit is an independent level
// Notes: only the second stage may be read by logic
`default_nettype none
module cts_sync2 #(
   parameter WIDTH = 1
) (
   input wire clock,
   input wire rst,
   input wire [WIDTH-1:0] asyncIn,
   output reg [WIDTH-1:0] syncOut
);
   reg [WIDTH-1:0] stage1_reg;

   always @(posedge clock) begin
      if (rst) begin
         stage1_reg <= {WIDTH{1'b0}};
         syncOut <= {WIDTH{1'b0}};
      end else begin
         stage1_reg <= asyncIn;
         syncOut <= stage1_reg;
      end
   end
endmodule // cts_sync2
`default_nettype wire

// *** hdl/cts_pulse_gen.v ***
// Purpose: fixed-length notification pulse started by a one-cycle trigger
// Assumes: trigger is a single-cycle onset event
// Notes: a trigger during a pulse extends nothing; the pulse length is fixed
`default_nettype none
module cts_pulse_gen #(
   parameter LENGTH = 5120,
   parameter CW = 16
) (
   input wire clock,
   input wire rst,
   input wire trigger,
   output reg pulse
);
   reg [CW-1:0] count_reg;

   always @(posedge clock) begin
      if (rst) begin
         count_reg <= {CW{1'b0}};
         pulse <= 1'b0;
      end else if (pulse) begin
         if (count_reg == LENGTH[CW-1:0] - {{(CW-1){1'b0}}, 1'b1}) begin
            pulse <= 1'b0;
            count_reg <= {CW{1'b0}};
         end else begin
            count_reg <= count_reg + {{(CW-1){1'b0}}, 1'b1};
         end
      end else if (trigger) begin
         pulse <= 1'b1;
         count_reg <= {CW{1'b0}};
      end
   end
endmodule // cts_pulse_gen
`default_nettype wire

// *** hdl/cts_supervisor.v ***
// Purpose: charge safety timer, host watchdog, accessory switch and thermistor supervisor
// Assumes: APB slave at 40 MHz; analog status arrives as asynchronous pins
// Notes: power-on is modelled by rst; status and interrupt pins are open-drain
`include "cts_map.vh"
`default_nettype none
module cts_supervisor #(
   parameter PULSE_CYCLES = `CTS_PULSE_US * `CTS_CLOCK_KHZ / 1000,
   parameter MS_CYCLES = `CTS_CLOCK_KHZ,
   parameter WATCHDOG_MS = `CTS_WATCHDOG_MS,
   parameter MS_PER_MIN = `CTS_MS_PER_MIN,
   parameter DEGLITCH_CYCLES = `CTS_DEGLITCH_US * `CTS_CLOCK_KHZ / 1000
) (
   input wire clock,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output wire pslverr,
   output reg [31:0] prdata,
   input wire powerSourceSelect,
   input wire hwChargeDisable,
   input wire supplyPresent,
   input wire faultyAdapter,
   input wire inputUndervoltage,
   input wire thermalShutdown,
   input wire chargeTerminated,
   input wire accessoryAtLimit,
   input wire thermistorCold,
   input wire thermistorWarm,
   input wire thermistorHot,
   output reg chargeEnable,
   output reg highImpedance,
   output reg driverSupplyRegulatorEn,
   output reg accessoryPowerSwitchOn,
   output reg [1:0] accessoryLimitSel,
   output reg inputLimitEnable,
   output reg [1:0] inputCurrentLimitSetting,
   output reg [3:0] chargeCurrentSetting,
   output reg [5:0] regulationVoltageSetting,
   output reg warmCurrentCap,
   output wire statusOut,
   output reg statusOe,
   output wire intOut,
   output reg intOe
);
   ////////////////////////////////////////////////////////////////////////////
   // input synchronisation
   wire [9:0] pinS;
   cts_sync2 #(.WIDTH(10)) pinSync (
      .clock(clock),
      .rst(rst),
      .asyncIn({powerSourceSelect, hwChargeDisable, supplyPresent, faultyAdapter,
                inputUndervoltage, thermalShutdown, chargeTerminated, accessoryAtLimit,
                thermistorCold, thermistorHot}),
      .syncOut(pinS)
   );
   wire pselS = pinS[9];
   wire hwDisS = pinS[8];
   wire supplyS = pinS[7];
   wire faultyS = pinS[6];
   wire uvloS = pinS[5];
   wire tsdS = pinS[4];
   wire termS = pinS[3];
   wire accLimS = pinS[2];
   wire coldS = pinS[1];
   wire hotS = pinS[0];
   wire [0:0] warmS;
   cts_sync2 #(.WIDTH(1)) warmSync (
      .clock(clock),
      .rst(rst),
      .asyncIn(thermistorWarm),
      .syncOut(warmS)
   );

   ////////////////////////////////////////////////////////////////////////////
   // register state
   reg startDone_reg;
   reg [1:0] startCnt_reg;
   reg usbSource_reg;
   reg defaultMode_reg;
   reg chgDis_reg;
   reg kick_reg;
   reg limOff_reg;
   reg enStat_reg;
   reg [1:0] limSel_reg;
   reg accEn_reg;
   reg [1:0] accLim_reg;
   reg [1:0] safeSel_reg;
   reg [3:0] ichg_reg;
   reg [5:0] vreg_reg;
   reg safetyFault_reg;
   reg accFault_reg;
   reg [1:0] thermFault_reg;
   reg [2:0] faultCode_reg;
   reg wdRunning_reg;
   reg [31:0] wdCount_reg;
   reg [31:0] msPre_reg;
   reg [31:0] safeMs_reg;
   reg [15:0] safeMin_reg;
   reg [15:0] accGlitch_reg;
   reg [1:0] thermZone_reg;

   wire setupPhase = psel & ~penable;
   wire accessDone = psel & penable;
   wire addrOk = (paddr == `CTS_OFF_CTRL) | (paddr == `CTS_OFF_TIMER) |
                 (paddr == `CTS_OFF_SETTING) | (paddr == `CTS_OFF_STATUS);
   wire wrCtrl = accessDone & pwrite & (paddr == `CTS_OFF_CTRL);
   wire wrTimer = accessDone & pwrite & (paddr == `CTS_OFF_TIMER);
   wire wrSetting = accessDone & pwrite & (paddr == `CTS_OFF_SETTING);
   wire hostWrite = wrCtrl | wrTimer | wrSetting;
   assign pready = 1'b1;
   assign pslverr = accessDone & ~addrOk;

   ////////////////////////////////////////////////////////////////////////////
   // derived conditions
   wire msTick = (msPre_reg == MS_CYCLES - 1);
   wire wdExpire = wdRunning_reg & msTick & (wdCount_reg == WATCHDOG_MS - 1);
   wire [15:0] safeLimit = (safeSel_reg == 2'h0) ? `CTS_SAFE_MIN_0 :
                           (safeSel_reg == 2'h1) ? `CTS_SAFE_MIN_1 :
                           `CTS_SAFE_MIN_2;
   wire regOk = supplyS & ~faultyS & ~uvloS & ~tsdS;
   wire thermSuspend = defaultMode_reg & (coldS | hotS);
   wire chargeRun = startDone_reg & ~chgDis_reg & ~hwDisS & ~safetyFault_reg & ~termS &
                    regOk & ~thermSuspend;
   wire minTick = chargeRun & msTick & (safeMs_reg == MS_PER_MIN - 1);
   wire safeExpire = minTick & (safeSel_reg != `CTS_SAFE_SEL_OFF) &
                     (safeMin_reg == safeLimit - 16'h0001);
   wire chgToggle = wrCtrl & (pwdata[`CTS_CTRL_CHG_DIS] != chgDis_reg);
   wire durChange = wrTimer & (pwdata[1:0] != safeSel_reg);
   wire safeRestart = chgToggle | durChange | wdExpire | (defaultMode_reg & hwDisS);
   wire accTrip = accEn_reg & accLimS & (accGlitch_reg == DEGLITCH_CYCLES - 1);
   wire [1:0] thermZone = coldS ? `CTS_THERM_COLD : hotS ? `CTS_THERM_HOT :
                          warmS[0] ? `CTS_THERM_WARM : `CTS_THERM_NONE;
   wire thermOnset = ~defaultMode_reg & (thermZone != `CTS_THERM_NONE) &
                     (thermZone != thermZone_reg);
   wire faultEvent = safeExpire | accTrip | thermOnset;
   wire notifyPulse;

   cts_pulse_gen #(.LENGTH(PULSE_CYCLES), .CW(16)) notifier (
      .clock(clock),
      .rst(rst),
      .trigger(faultEvent),
      .pulse(notifyPulse)
   );

   ////////////////////////////////////////////////////////////////////////////
   // startup, mode and host registers
   always @(posedge clock) begin
      if (rst) begin
         startDone_reg <= 1'b0;
         startCnt_reg <= 2'h0;
         usbSource_reg <= 1'b0;
         defaultMode_reg <= 1'b1;
         chgDis_reg <= 1'b0;
         kick_reg <= 1'b0;
         limOff_reg <= 1'b1;
         enStat_reg <= 1'b0;
         limSel_reg <= `CTS_RST_LIM_SEL;
         accEn_reg <= 1'b0;
         accLim_reg <= `CTS_RST_ACC_LIM;
         safeSel_reg <= `CTS_RST_SAFE_SEL;
         ichg_reg <= `CTS_RST_ICHG;
         vreg_reg <= `CTS_RST_VREG;
      end else begin
         if (!startDone_reg) begin
            startCnt_reg <= startCnt_reg + 2'h1;
            if (startCnt_reg == `CTS_STARTUP_WAIT) begin
               startDone_reg <= 1'b1;
               usbSource_reg <= pselS;
               limOff_reg <= ~pselS;
            end
         end
         kick_reg <= 1'b0;
         if (wdExpire && !safetyFault_reg) begin
            defaultMode_reg <= 1'b1;
            chgDis_reg <= 1'b0;
            limOff_reg <= ~usbSource_reg;
            enStat_reg <= 1'b0;
            limSel_reg <= `CTS_RST_LIM_SEL;
            accEn_reg <= 1'b0;
            accLim_reg <= `CTS_RST_ACC_LIM;
            safeSel_reg <= `CTS_RST_SAFE_SEL;
            ichg_reg <= `CTS_RST_ICHG;
            vreg_reg <= `CTS_RST_VREG;
         end else begin
            if (hostWrite) begin
               defaultMode_reg <= 1'b0;
            end
            if (wrCtrl) begin
               chgDis_reg <= pwdata[`CTS_CTRL_CHG_DIS];
               kick_reg <= pwdata[`CTS_CTRL_KICK];
               limOff_reg <= pwdata[`CTS_CTRL_LIM_OFF];
               enStat_reg <= pwdata[`CTS_CTRL_EN_STAT];
               limSel_reg <= pwdata[`CTS_CTRL_LIM_SEL_HI:`CTS_CTRL_LIM_SEL_LO];
               accLim_reg <= pwdata[`CTS_CTRL_ACC_LIM_HI:`CTS_CTRL_ACC_LIM_LO];
            end
            if (accTrip) begin
               accEn_reg <= 1'b0;
            end else if (wrCtrl) begin
               accEn_reg <= pwdata[`CTS_CTRL_ACC_EN];
            end
            if (wrTimer) begin
               safeSel_reg <= pwdata[1:0];
            end
            if (wrSetting) begin
               ichg_reg <= pwdata[`CTS_SET_ICHG_HI:`CTS_SET_ICHG_LO];
               vreg_reg <= pwdata[`CTS_SET_VREG_HI:`CTS_SET_VREG_LO];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // watchdog and safety timer
   always @(posedge clock) begin
      if (rst) begin
         msPre_reg <= 32'h0;
         wdRunning_reg <= 1'b0;
         wdCount_reg <= 32'h0;
         safeMs_reg <= 32'h0;
         safeMin_reg <= 16'h0;
         safetyFault_reg <= 1'b0;
      end else begin
         msPre_reg <= msTick ? 32'h0 : msPre_reg + 32'h1;
         if (wdExpire) begin
            wdRunning_reg <= 1'b0;
            wdCount_reg <= 32'h0;
         end else if (kick_reg) begin
            wdCount_reg <= 32'h0;
         end else if (accessDone && !wdRunning_reg) begin
            wdRunning_reg <= 1'b1;
            wdCount_reg <= 32'h0;
         end else if (wdRunning_reg && msTick) begin
            wdCount_reg <= wdCount_reg + 32'h1;
         end
         if (safeRestart) begin
            safeMs_reg <= 32'h0;
            safeMin_reg <= 16'h0;
         end else if (chargeRun && msTick) begin
            safeMs_reg <= minTick ? 32'h0 : safeMs_reg + 32'h1;
            if (minTick) begin
               safeMin_reg <= safeMin_reg + 16'h0001;
            end
         end
         if (safeExpire) begin
            safetyFault_reg <= 1'b1;
         end else if (chgToggle) begin
            safetyFault_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // accessory deglitch and fault recording
   always @(posedge clock) begin
      if (rst) begin
         accGlitch_reg <= 16'h0;
         accFault_reg <= 1'b0;
         thermFault_reg <= `CTS_THERM_NONE;
         thermZone_reg <= `CTS_THERM_NONE;
         faultCode_reg <= `CTS_FAULT_NONE;
      end else begin
         thermZone_reg <= thermZone;
         if (accEn_reg && accLimS && !accTrip) begin
            accGlitch_reg <= accGlitch_reg + 16'h0001;
         end else begin
            accGlitch_reg <= 16'h0;
         end
         if (accTrip) begin
            accFault_reg <= 1'b1;
         end else if (wrCtrl && pwdata[`CTS_CTRL_ACC_EN]) begin
            accFault_reg <= 1'b0;
         end
         if (thermOnset) begin
            thermFault_reg <= thermZone;
         end
         if (safeExpire) begin
            faultCode_reg <= `CTS_FAULT_TIMER;
         end else if (accTrip) begin
            faultCode_reg <= `CTS_FAULT_ACCESSORY;
         end else if (thermOnset) begin
            faultCode_reg <= `CTS_FAULT_TEMP;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data, captured in the setup cycle
   wire [1:0] chargeState = safetyFault_reg ? `CTS_STATE_FAULT :
                            termS ? `CTS_STATE_DONE :
                            chargeRun ? `CTS_STATE_CHARGING : `CTS_STATE_READY;
   always @(posedge clock) begin
      if (rst) begin
         prdata <= 32'h0;
      end else if (setupPhase && !pwrite) begin
         case (paddr)
            `CTS_OFF_CTRL: prdata <= {23'h0, accLim_reg, accEn_reg, limSel_reg, enStat_reg,
                                      limOff_reg, kick_reg, chgDis_reg};
            `CTS_OFF_TIMER: prdata <= {30'h0, safeSel_reg};
            `CTS_OFF_SETTING: prdata <= {22'h0, vreg_reg, ichg_reg};
            `CTS_OFF_STATUS: prdata <= {21'h0, accFault_reg, wdRunning_reg, usbSource_reg,
                                        defaultMode_reg, thermFault_reg, faultCode_reg,
                                        chargeState};
            default: prdata <= 32'h0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin outputs
   assign statusOut = 1'b0;
   assign intOut = 1'b0;
   always @(posedge clock) begin
      if (rst) begin
         chargeEnable <= 1'b0;
         highImpedance <= 1'b0;
         driverSupplyRegulatorEn <= 1'b0;
         accessoryPowerSwitchOn <= 1'b0;
         accessoryLimitSel <= `CTS_RST_ACC_LIM;
         inputLimitEnable <= 1'b0;
         inputCurrentLimitSetting <= `CTS_RST_LIM_SEL;
         chargeCurrentSetting <= `CTS_RST_ICHG;
         regulationVoltageSetting <= `CTS_RST_VREG;
         warmCurrentCap <= 1'b0;
         statusOe <= 1'b0;
         intOe <= 1'b0;
      end else begin
         chargeEnable <= chargeRun;
         highImpedance <= hwDisS;
         driverSupplyRegulatorEn <= regOk;
         accessoryPowerSwitchOn <= accEn_reg & ~accTrip;
         accessoryLimitSel <= accLim_reg;
         inputLimitEnable <= ~limOff_reg & (usbSource_reg | ~defaultMode_reg);
         inputCurrentLimitSetting <= limSel_reg;
         chargeCurrentSetting <= ichg_reg;
         regulationVoltageSetting <= vreg_reg;
         warmCurrentCap <= defaultMode_reg & ~usbSource_reg & warmS[0] & ~hotS;
         statusOe <= notifyPulse | (enStat_reg & chargeRun);
         intOe <= notifyPulse | (enStat_reg & chargeRun);
      end
   end
endmodule // cts_supervisor
`default_nettype wire

// *** verification/cts_checker.sv ***
// Purpose: port assertions for the charger supervisor
// Assumes: sim-scale counts; status enable bit stays clear
// Notes: bound from the bench top
`default_nettype none
module cts_checker #(
   parameter PULSE_CYCLES = 8
) (
   input wire clock,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire hwChargeDisable,
   input wire supplyPresent,
   input wire faultyAdapter,
   input wire inputUndervoltage,
   input wire thermalShutdown,
   input wire accessoryAtLimit,
   input wire chargeEnable,
   input wire highImpedance,
   input wire driverSupplyRegulatorEn,
   input wire accessoryPowerSwitchOn,
   input wire [1:0] accessoryLimitSel,
   input wire inputLimitEnable,
   input wire statusOe,
   input wire intOe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   wire wrCtrl = psel && penable && pwrite && paddr == 12'h000;
   wire bad = faultyAdapter || inputUndervoltage || thermalShutdown;
   wire good = supplyPresent && !bad;
   wire [1:0] accWr = pwdata[8:7];
   logic [15:0] oeLen;
   // length of the current pin pulse
   always_ff @(posedge clock) begin
      if (rst || !statusOe) oeLen <= 16'h0;
      else oeLen <= oeLen + 16'h1;
   end
   ////////////////////
   AST_HIZ_DIS: assert property (hwChargeDisable [*4] |-> highImpedance)
      else $error("hiz missing");
   AST_HIZ_CHG: assert property (highImpedance [*2] |-> !chargeEnable)
      else $error("charging in hiz");
   AST_REGULATOR_ON: assert property (good [*4] |-> driverSupplyRegulatorEn)
      else $error("driver off");
   AST_REGULATOR_OFF: assert property (bad [*4] |-> !driverSupplyRegulatorEn)
      else $error("driver on");
   AST_PULSE_LEN: assert property ($fell(statusOe) |-> oeLen == PULSE_CYCLES)
      else $error("pulse length");
   AST_PIN_PAIR: assert property (statusOe == intOe)
      else $error("pins differ");
   AST_ACC_TRIP: assert property (accessoryAtLimit [*8] |->
      ##[0:4] !accessoryPowerSwitchOn) else $error("no trip");
   // register then output flop: the code shows two edges after the write
   AST_ACC_LIM: assert property (wrCtrl |=> ##1 accessoryLimitSel == $past(accWr, 2))
      else $error("limit code");
   AST_CHG_DIS: assert property (wrCtrl && pwdata[0] |-> ##[1:2] !chargeEnable)
      else $error("still charging");
   AST_LIM_OFF: assert property (wrCtrl && pwdata[2] |-> ##[1:2] !inputLimitEnable)
      else $error("limit kept");
   cover property ($rose(statusOe));
   cover property ($fell(accessoryPowerSwitchOn));
   cover property (wrCtrl && pwdata[1]);
endmodule // cts_checker
`default_nettype wire

// *** verification/cts_host_model.sv ***
// Purpose: host processor on the register port
// Assumes: one transfer at a time
// Notes: request held until pready is seen high
`default_nettype none
module cts_host_model (
   input wire clock,
   input wire pready,
   input wire pslverr,
   input wire [31:0] prdata,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end
   // setup, access until pready, then release
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
         output logic [31:0] q, output logic err);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule // cts_host_model
`default_nettype wire

// *** verification/cts_supervisor_tb.sv ***
// Purpose: self-checking bench for the charger supervisor
// Assumes: sim-scale counts, host model on the register port
// Notes: seed 59 feeds the setting values
`default_nettype none
module cts_supervisor_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, rst, psel, penable, pwrite, pready, pslverr, e, prevOe;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, d, ctrl;
   logic powerSourceSelect, hwChargeDisable, supplyPresent, faultyAdapter;
   logic inputUndervoltage, thermalShutdown, chargeTerminated, accessoryAtLimit;
   logic thermistorCold, thermistorWarm, thermistorHot, chargeEnable, highImpedance;
   logic driverSupplyRegulatorEn, accessoryPowerSwitchOn, inputLimitEnable;
   logic warmCurrentCap, statusOut, statusOe, intOut, intOe;
   logic [1:0] accessoryLimitSel, inputCurrentLimitSetting;
   logic [3:0] chargeCurrentSetting;
   logic [5:0] regulationVoltageSetting;
   logic [31:0] setWord;
   assign setWord = {22'h0, regulationVoltageSetting, chargeCurrentSetting};
   int errors, comparisons, rises, r, n, i;
   integer seed;
   cts_supervisor #(.PULSE_CYCLES(8), .MS_CYCLES(4), .WATCHDOG_MS(10), .MS_PER_MIN(5),
      .DEGLITCH_CYCLES(4)) dut (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pready, .pslverr, .prdata, .powerSourceSelect, .hwChargeDisable, .supplyPresent,
      .faultyAdapter, .inputUndervoltage, .thermalShutdown, .chargeTerminated,
      .accessoryAtLimit, .thermistorCold, .thermistorWarm, .thermistorHot, .chargeEnable,
      .highImpedance, .driverSupplyRegulatorEn, .accessoryPowerSwitchOn,
      .accessoryLimitSel, .inputLimitEnable, .inputCurrentLimitSetting,
      .chargeCurrentSetting, .regulationVoltageSetting, .warmCurrentCap, .statusOut,
      .statusOe, .intOut, .intOe);
   cts_host_model host (.clock, .pready, .pslverr, .prdata, .psel, .penable, .pwrite,
      .paddr, .pwdata);
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   always @(posedge clock) begin
      if (statusOe === 1'b1 && prevOe === 1'b0) rises <= rises + 1;
      prevOe <= statusOe;
   end
   ////////////////////
   task automatic cmpBit(input string nm, input logic x, input logic s);
      comparisons++;
      if (s !== x) begin
         errors++;
         $display("wrong value %s expected %b seen %b", nm, x, s);
      end
   endtask
   task automatic cmpVal(input string nm, input logic [31:0] x, input logic [31:0] s);
      comparisons++;
      if (s !== x) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, x, s);
      end
   endtask
   // status bits 6:2 for a thermistor zone with the temperature fault code
   function automatic logic [31:0] zoneCode(input int z);
      return {27'h0, z[1:0], 3'h3};
   endfunction
   task automatic tick(input int k);
      repeat (k) @(posedge clock);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      host.xfer(1'b1, a, v, q, e);
   endtask
   task automatic rd(input logic [11:0] a);
      host.xfer(1'b0, a, 32'h0, q, e);
   endtask
   task automatic doReset(input logic ps);
      rst <= 1'b1;
      powerSourceSelect <= ps;
      tick(6);
      rst <= 1'b0;
      tick(8);
   endtask
   task automatic print_verdict();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      tick(5000);
      errors++;
      print_verdict();
   end
   ////////////////////
   initial begin
      seed = 59;
      rst = 1'b1;
      {powerSourceSelect, hwChargeDisable, faultyAdapter, inputUndervoltage} = 4'h0;
      {thermalShutdown, chargeTerminated, accessoryAtLimit} = 3'h0;
      {thermistorCold, thermistorWarm, thermistorHot} = 3'h0;
      supplyPresent = 1'b1;
      doReset(1'b0);
      cmpBit("ilim", 1'b0, inputLimitEnable);
      cmpVal("defaults", 32'h56, setWord);
      cmpBit("charging", 1'b1, chargeEnable);
      thermistorCold <= 1'b1;
      tick(6);
      cmpBit("cold", 1'b0, chargeEnable);
      thermistorCold <= 1'b0;
      thermistorWarm <= 1'b1;
      tick(6);
      cmpBit("warm cap", 1'b1, warmCurrentCap);
      thermistorWarm <= 1'b0;
      tick(200);
      hwChargeDisable <= 1'b1;
      tick(6);
      cmpBit("hiz", 1'b1, highImpedance);
      hwChargeDisable <= 1'b0;
      tick(6);
      n = 6;
      while (chargeEnable !== 1'b0 && n < 900) begin
         tick(1);
         n++;
      end
      cmpBit("safety span", 1'b1, n > 520 && n < 570);
      tick(3);
      cmpBit("fault pin", 1'b1, statusOe);
      rd(12'h00c);
      cmpVal("timer fault", 32'h13, {27'h0, q[4:0]});
      wr(12'h000, 32'h1);
      wr(12'h000, 32'h0);
      tick(4);
      cmpBit("fault cleared", 1'b1, chargeEnable);
      cmpVal("pulses", 32'h1, rises);
      for (i = 0; i < 4; i++) begin
         wr(12'h000, {23'h0, i[1:0], 1'b1, i[1:0], 4'h2});
         tick(3);
         cmpVal("limits", {28'h0, i[1:0], i[1:0]},
            {28'h0, inputCurrentLimitSetting, accessoryLimitSel});
         cmpBit("acc on", 1'b1, accessoryPowerSwitchOn);
         cmpBit("ilim on", 1'b1, inputLimitEnable);
         tick(27);
      end
      rd(12'h000);
      cmpVal("ctrl", 32'h1f0, q);
      ctrl = 32'h1c6;
      wr(12'h000, ctrl);
      tick(2);
      cmpBit("ilim off", 1'b0, inputLimitEnable);
      accessoryAtLimit <= 1'b1;
      tick(2);
      accessoryAtLimit <= 1'b0;
      tick(4);
      cmpBit("glitch", 1'b1, accessoryPowerSwitchOn);
      r = rises;
      accessoryAtLimit <= 1'b1;
      tick(14);
      cmpBit("acc trip", 1'b0, accessoryPowerSwitchOn);
      tick(6);
      cmpVal("one pulse", r + 1, rises);
      rd(12'h00c);
      cmpVal("acc fault", 32'h9, {28'h0, q[10], q[4:2]});
      cmpBit("wd running", 1'b1, q[9]);
      accessoryAtLimit <= 1'b0;
      wr(12'h000, ctrl);
      tick(3);
      cmpBit("acc again", 1'b1, accessoryPowerSwitchOn);
      wr(12'h004, 32'h1);
      rd(12'h004);
      cmpVal("timer sel", 32'h1, q);
      rd(12'h010);
      cmpBit("slverr", 1'b1, e);
      cmpVal("unmapped", 32'h0, q);
      for (i = 1; i < 4; i++) begin
         wr(12'h000, ctrl);
         r = rises;
         thermistorCold <= i == 1;
         thermistorWarm <= i == 2;
         thermistorHot <= i == 3;
         tick(12);
         cmpVal("zone pulse", r + 1, rises);
         cmpBit("host charge", 1'b1, chargeEnable);
         rd(12'h00c);
         cmpVal("zone code", zoneCode(i), {27'h0, q[6:2]});
         {thermistorCold, thermistorWarm, thermistorHot} <= 3'h0;
         tick(4);
      end
      for (i = 0; i < 4; i++) begin
         d = $random(seed);
         wr(12'h008, d);
         wr(12'h000, ctrl);
      end
      cmpVal("setting", {22'h0, d[9:0]}, setWord);
      wr(12'h000, ctrl | 32'h1);
      tick(3);
      cmpBit("disabled", 1'b0, chargeEnable);
      tick(60);
      cmpVal("restored", 32'h56, setWord);
      cmpBit("resumed", 1'b1, chargeEnable);
      cmpBit("acc reset", 1'b0, accessoryPowerSwitchOn);
      doReset(1'b1);
      cmpBit("usb ilim", 1'b1, inputLimitEnable);
      cmpVal("usb code", 32'h6, {26'h0, inputCurrentLimitSetting, chargeCurrentSetting});
      thermistorWarm <= 1'b1;
      tick(6);
      cmpBit("usb warm", 1'b0, warmCurrentCap);
      thermistorWarm <= 1'b0;
      inputUndervoltage <= 1'b1;
      tick(6);
      cmpBit("driver off", 1'b0, driverSupplyRegulatorEn);
      inputUndervoltage <= 1'b0;
      tick(6);
      cmpBit("driver on", 1'b1, driverSupplyRegulatorEn);
      print_verdict();
   end
endmodule // cts_supervisor_tb
bind cts_supervisor cts_checker #(.PULSE_CYCLES(PULSE_CYCLES)) chk (.clock, .rst, .psel,
   .penable, .pwrite, .paddr, .pwdata, .hwChargeDisable, .supplyPresent, .faultyAdapter,
   .inputUndervoltage, .thermalShutdown, .accessoryAtLimit, .chargeEnable, .highImpedance,
   .driverSupplyRegulatorEn, .accessoryPowerSwitchOn, .accessoryLimitSel,
   .inputLimitEnable, .statusOe, .intOe);
`default_nettype wire
